/* File: inc/npic_pkg.sv */
// constants, types and helpers of the nested priority interrupt controller
package npic_pkg;

    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam int         NVEC       = 14;
    localparam logic [7:0] OFF_PRIO0  = 8'h00;
    localparam logic [7:0] OFF_PRIO1  = 8'h04;
    localparam logic [7:0] OFF_PRIO2  = 8'h08;
    localparam logic [7:0] OFF_PRIO3  = 8'h0C;
    localparam logic [7:0] OFF_PEND   = 8'h10;
    localparam logic [7:0] OFF_CC     = 8'h14;
    localparam logic [7:0] OFF_SENSE  = 8'h18;
    localparam logic [7:0] OFF_PINSEL = 8'h1C;
    localparam logic [7:0] OFF_CTRL   = 8'h20;
    localparam logic [1:0] FLD_RST    = 2'h3;
    localparam logic [7:0] SENSE_RST  = 8'h00;
    localparam logic [15:0] PINSEL_RST = 16'h1111;
    localparam logic       NESTED_RST = 1'b1;
    localparam int         CC_HI_BIT  = 5;
    localparam int         CC_LO_BIT  = 3;

    // ------------------------------------------------------------
    // priority codes, vectors, sources
    // ------------------------------------------------------------
    localparam logic [1:0] PRIO_L0 = 2'h2;
    localparam logic [1:0] PRIO_L1 = 2'h1;
    localparam logic [1:0] PRIO_L2 = 2'h0;
    localparam logic [1:0] PRIO_L3 = 2'h3;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
    localparam logic [15:0] VEC_BASE  = 16'hFFFA;
    localparam logic [13:0] HALT_CAP  = 14'h00BC;
    localparam logic [13:0] EXT_MASK  = 14'h003C;
    localparam int         EXT_FIRST  = 2;
    localparam logic [1:0] SNS_FALL_LOW = 2'h0;
    localparam logic [1:0] SNS_RISE     = 2'h1;
    localparam logic [1:0] SNS_FALL     = 2'h2;
    localparam logic [2:0] SEL_PCL = 3'h0;
    localparam logic [2:0] SEL_PCH = 3'h1;
    localparam logic [2:0] SEL_X   = 3'h2;
    localparam logic [2:0] SEL_A   = 3'h3;
    localparam logic [2:0] SEL_CC  = 3'h4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_HALT} npic_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_VEC, ST_POP} npic_state_t;
    typedef enum logic [1:0] {K_RESET, K_TRAP, K_MASK} npic_kind_t;

    // priority code to numeric level, 0 lowest
    function automatic logic [1:0] npic_lvl(input logic [1:0] code);
        case (code)
            PRIO_L0: npic_lvl = 2'h0;
            PRIO_L1: npic_lvl = 2'h1;
            PRIO_L2: npic_lvl = 2'h2;
            default: npic_lvl = 2'h3;
        endcase
    endfunction

endpackage

/* File: hw/npic_ctrl.sv */
// nested priority interrupt controller with an AHB-Lite register slave
`timescale 1ns/1ps

// Overview of operation
// - divert only after current instruction completes
// - stack PC, X, A, CC on entry
// - maskable entry loads vector priority bits
// - load vector address, then fetch handler
// - return pops context and restores priority
// - codes: L0=10, L1=01, L2=00, L3=11
// - highest software priority wins, then hardware
// - unserviced requests stay latched as pending
// - reset and trap outrank all levels
// - non-maskable sources ignore current priority
// - non-maskable entry forces level 3
// - non-maskable sources leave halt
// - first routine after reset at level 3
// - service only above current level, else pend
// - edge latch cleared on handler entry
// - selected pins of a group are ORed
// - any source wakes wait; capable ones halt
// - peripheral request needs flag and enable
// - clear sequence discards pending peripheral request
// - first after halt must be halt-capable
// - concurrent blocks preemption, nested allows higher
// - lower source number means higher priority
// - two-bit fields per vector reset to ones
// - level-0 code writes to fields are ignored
module npic_ctrl
    import npic_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        INSTR_END,
    input  wire logic        TRAP_REQ,
    input  wire logic        INTERRUPT_RETURN_INSTR_REQ,
    input  wire logic [7:0]  POP_DATA,
    input  wire logic        PRIO_LOAD,
    input  wire logic [1:0]  PRIO_VAL,
    input  wire logic        WAIT_ENTER,
    input  wire logic        HALT_ENTER,
    input  wire logic [15:0] EXT_PIN,
    input  wire logic [13:0] PERIPH_FLAG,
    input  wire logic [13:0] PERIPH_EN,
    input  wire logic [13:0] PERIPH_CLR,
    output logic             CPU_SUSPEND,
    output logic             PUSH_STB,
    output logic      [2:0]  PUSH_SEL,
    output logic             POP_STB,
    output logic      [2:0]  POP_SEL,
    output logic             VEC_STB,
    output logic      [15:0] VEC_ADDR,
    output logic      [1:0]  CUR_PRIO,
    output logic      [1:0]  SLEEP_MODE,
    output logic             WAKE_STB
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    npic_state_t state;
    npic_kind_t  kind;
    npic_mode_t  mode;
    logic [1:0]  fld [NVEC];
    logic [7:0]  sense;
    logic [15:0] pinsel;
    logic        nested;
    logic [1:0]  cur_prio;
    logic [3:0]  depth;
    logic        reset_go;
    logic        halt_exit;
    logic [3:0]  sel_vec;
    logic [1:0]  cap_l;
    logic [15:0] s1, s2, s3, filt;
    logic [3:0]  grp, grp_q, lat, edge_set, ext_req, ent_clr;
    logic [13:0] plat, pend;
    logic        best_ok;
    logic [3:0]  best_v;
    logic [1:0]  best_l;
    logic        hmask;
    logic        wr_pend, rd_pend;
    logic [7:0]  a_q;
    logic [31:0] pr, rd_val;
    logic        ap;
    logic        any_l0;

    // ------------------------------------------------------------
    // AHB-Lite slave: writes zero wait, reads one wait state
    // ------------------------------------------------------------
    assign ap = HSEL && HREADY && HTRANS[1];

    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            a_q       <= 8'h00;
            HREADYOUT <= 1'b1;
            HRDATA    <= 32'h0000_0000;
            HRESP     <= 1'b0;
        end else begin
            HRESP   <= 1'b0; // every transfer answers OKAY
            wr_pend <= ap && HWRITE && HSIZE == HSIZE_WORD;
            if (ap) begin
                a_q <= HADDR[7:0];
            end
            if (ap && !HWRITE) begin
                rd_pend   <= 1'b1;
                HREADYOUT <= 1'b0;
            end else if (rd_pend) begin
                rd_pend   <= 1'b0;
                HRDATA    <= rd_val;
                HREADYOUT <= 1'b1;
            end
        end
    end

    // packed fields; top nibble of the last byte reads as ones
    always_comb begin
        pr     = 32'hFFFF_FFFF;
        any_l0 = 1'b0;
        for (int v = 0; v < NVEC; v++) begin
            pr[2*v+:2] = fld[v];
            any_l0     = any_l0 | (fld[v] == PRIO_L0);
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        case (a_q)
            OFF_PRIO0:  rd_val = {24'h000000, pr[7:0]};
            OFF_PRIO1:  rd_val = {24'h000000, pr[15:8]};
            OFF_PRIO2:  rd_val = {24'h000000, pr[23:16]};
            OFF_PRIO3:  rd_val = {24'h000000, pr[31:24]};
            OFF_PEND:   rd_val = {18'h00000, pend};
            OFF_CC:     rd_val = {24'h000000, 2'b11, cur_prio[1], 1'b0,
                                  cur_prio[0], 3'b000};
            OFF_SENSE:  rd_val = {24'h000000, sense};
            OFF_PINSEL: rd_val = {16'h0000, pinsel};
            OFF_CTRL:   rd_val = {31'h00000000, nested};
            default:    rd_val = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // a level-0 code in one field leaves that field alone only
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int v = 0; v < NVEC; v++) begin
                fld[v] <= FLD_RST;
            end
        end else begin
            for (int v = 0; v < NVEC; v++) begin
                if (wr_pend && a_q == OFF_PRIO0 + 8'(4 * (v / 4))
                    && HWDATA[2*(v%4)+:2] != PRIO_L0) begin
                    fld[v] <= HWDATA[2*(v%4)+:2];
                end
            end
        end
    end

    // sensitivity, pin selection and nesting mode
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sense  <= SENSE_RST;
            pinsel <= PINSEL_RST;
            nested <= NESTED_RST;
        end else begin
            if (wr_pend && a_q == OFF_SENSE) begin
                sense <= HWDATA[7:0];
            end
            if (wr_pend && a_q == OFF_PINSEL) begin
                pinsel <= HWDATA[15:0];
            end
            if (wr_pend && a_q == OFF_CTRL) begin
                nested <= HWDATA[0];
            end
        end
    end

    // ------------------------------------------------------------
    // external lines
    // ------------------------------------------------------------
    // three stages; a bit moves only once stages two and three agree
    always_ff @(posedge CLK) begin
        if (RESET) begin
            s1    <= 16'hFFFF;
            s2    <= 16'hFFFF;
            s3    <= 16'hFFFF;
            filt  <= 16'hFFFF;
            grp_q <= 4'hF;
        end else begin
            s1    <= EXT_PIN;
            s2    <= s1;
            s3    <= s2;
            filt  <= (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
            grp_q <= grp;
        end
    end

    // group level and per-group trigger
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            grp[g] = |(filt[4*g+:4] & pinsel[4*g+:4]);
            case (sense[2*g+:2])
                SNS_FALL_LOW: edge_set[g] = grp_q[g] & ~grp[g];
                SNS_RISE:     edge_set[g] = ~grp_q[g] & grp[g];
                SNS_FALL:     edge_set[g] = grp_q[g] & ~grp[g];
                default:      edge_set[g] = grp_q[g] ^ grp[g];
            endcase
            ent_clr[g] = state == ST_VEC && kind == K_MASK
                         && sel_vec == 4'(EXT_FIRST + g);
            ext_req[g] = lat[g]
                         | (sense[2*g+:2] == SNS_FALL_LOW && !grp[g]);
        end
    end

    // edge latches: a new edge beats the entry clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            lat <= 4'h0;
        end else begin
            lat <= edge_set | (lat & ~ent_clr);
        end
    end

    // peripheral latches; the clear sequence drops a pending request
    always_ff @(posedge CLK) begin
        if (RESET) begin
            plat <= 14'h0000;
        end else begin
            plat <= (plat | (PERIPH_FLAG & PERIPH_EN))
                    & ~PERIPH_CLR & ~EXT_MASK;
        end
    end

    assign pend = plat | {8'h00, ext_req, 2'b00};

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    assign hmask = mode == MODE_HALT || halt_exit;

    // ascending scan with strict compare keeps the lower number on ties
    always_comb begin
        best_ok = 1'b0;
        best_v  = 4'h0;
        best_l  = 2'h0;
        for (int i = 0; i < NVEC; i++) begin
            if (pend[i] && npic_lvl(fld[i]) > npic_lvl(cur_prio)
                && (!hmask || HALT_CAP[i])
                && (!best_ok || npic_lvl(fld[i]) > best_l)) begin
                best_ok = 1'b1;
                best_v  = 4'(i);
                best_l  = npic_lvl(fld[i]);
            end
        end
        if (!nested && depth != 4'h0) begin
            best_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // service sequencer
    // ------------------------------------------------------------
    // reset, then trap, then return, then maskable requests
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state       <= ST_IDLE;
            kind        <= K_RESET;
            sel_vec     <= 4'h0;
            cap_l       <= 2'h0;
            CPU_SUSPEND <= 1'b0;
            PUSH_STB    <= 1'b0;
            PUSH_SEL    <= SEL_PCL;
            POP_STB     <= 1'b0;
            POP_SEL     <= SEL_CC;
            VEC_STB     <= 1'b0;
            VEC_ADDR    <= 16'h0000;
        end else begin
            VEC_STB <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (reset_go) begin
                        kind        <= K_RESET;
                        state       <= ST_VEC;
                        CPU_SUSPEND <= 1'b1;
                    end else if (TRAP_REQ) begin
                        kind        <= K_TRAP;
                        state       <= ST_PUSH;
                        PUSH_STB    <= 1'b1;
                        PUSH_SEL    <= SEL_PCL;
                        CPU_SUSPEND <= 1'b1;
                    end else if (INTERRUPT_RETURN_INSTR_REQ) begin
                        state       <= ST_POP;
                        POP_STB     <= 1'b1;
                        POP_SEL     <= SEL_CC;
                        CPU_SUSPEND <= 1'b1;
                    end else if (best_ok
                                 && (INSTR_END || mode != MODE_RUN)) begin
                        kind        <= K_MASK;
                        sel_vec     <= best_v;
                        cap_l       <= npic_lvl(cur_prio);
                        state       <= ST_PUSH;
                        PUSH_STB    <= 1'b1;
                        PUSH_SEL    <= SEL_PCL;
                        CPU_SUSPEND <= 1'b1;
                    end
                end
                ST_PUSH: begin
                    if (PUSH_SEL == SEL_CC) begin
                        PUSH_STB <= 1'b0;
                        state    <= ST_VEC;
                    end else begin
                        PUSH_SEL <= PUSH_SEL + 3'h1;
                    end
                end
                ST_VEC: begin
                    VEC_STB     <= 1'b1;
                    CPU_SUSPEND <= 1'b0;
                    state       <= ST_IDLE;
                    case (kind)
                        K_RESET: VEC_ADDR <= VEC_RESET;
                        K_TRAP:  VEC_ADDR <= VEC_TRAP;
                        default: VEC_ADDR <= VEC_BASE
                                             - 16'({sel_vec, 1'b0});
                    endcase
                end
                ST_POP: begin
                    if (POP_SEL == SEL_PCL) begin
                        POP_STB     <= 1'b0;
                        CPU_SUSPEND <= 1'b0;
                        state       <= ST_IDLE;
                    end else begin
                        POP_SEL <= POP_SEL - 3'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // reset vector runs once before anything else
    always_ff @(posedge CLK) begin
        if (RESET) begin
            reset_go <= 1'b1;
        end else if (state == ST_VEC && kind == K_RESET) begin
            reset_go <= 1'b0;
        end
    end

    // current priority; hardware entry outranks software loads
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cur_prio <= PRIO_L3;
        end else if (state == ST_VEC) begin
            cur_prio <= kind == K_MASK ? fld[sel_vec] : PRIO_L3;
        end else if (POP_STB && POP_SEL == SEL_CC) begin
            cur_prio <= {POP_DATA[CC_HI_BIT], POP_DATA[CC_LO_BIT]};
        end else if (PRIO_LOAD) begin
            cur_prio <= PRIO_VAL;
        end else if (wr_pend && a_q == OFF_CC) begin
            cur_prio <= {HWDATA[CC_HI_BIT], HWDATA[CC_LO_BIT]};
        end
    end

    assign CUR_PRIO = cur_prio;

    // nesting depth; the reset routine is not a handler
    always_ff @(posedge CLK) begin
        if (RESET) begin
            depth <= 4'h0;
        end else if (state == ST_VEC && kind != K_RESET) begin
            depth <= depth + 4'h1;
        end else if (POP_STB && POP_SEL == SEL_PCL && depth != 4'h0) begin
            depth <= depth - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // low power modes
    // ------------------------------------------------------------
    // halt_exit stays until the first maskable handler is entered; a trap entry leaves it set
    always_ff @(posedge CLK) begin
        if (RESET) begin
            mode      <= MODE_RUN;
            halt_exit <= 1'b0;
            WAKE_STB  <= 1'b0;
        end else begin
            WAKE_STB <= 1'b0;
            if (state == ST_VEC && kind == K_MASK) begin
                halt_exit <= 1'b0;
            end
            if (mode == MODE_WAIT && (|pend || TRAP_REQ)) begin
                mode     <= MODE_RUN;
                WAKE_STB <= 1'b1;
            end else if (mode == MODE_HALT
                         && (|(pend & HALT_CAP) || TRAP_REQ)) begin
                mode      <= MODE_RUN;
                halt_exit <= 1'b1;
                WAKE_STB  <= 1'b1;
            end else if (mode == MODE_RUN && WAIT_ENTER) begin
                mode <= MODE_WAIT;
            end else if (mode == MODE_RUN && HALT_ENTER) begin
                mode <= MODE_HALT;
            end
        end
    end

    assign SLEEP_MODE = 2'(mode);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_push;
        PUSH_SEL == SEL_PCL ##1 PUSH_SEL == SEL_PCH ##1 PUSH_SEL == SEL_X
        ##1 PUSH_SEL == SEL_A ##1 PUSH_SEL == SEL_CC;
    endsequence

    sequence s_pop;
        POP_SEL == SEL_CC ##1 POP_SEL == SEL_A ##1 POP_SEL == SEL_X
        ##1 POP_SEL == SEL_PCH ##1 POP_SEL == SEL_PCL;
    endsequence

    chk_push_then_vec: assert property (
        $rose(PUSH_STB) |-> s_push ##1 !PUSH_STB ##1 VEC_STB)
        else $error("context push order or vector load wrong");

    chk_boundary_wait: assert property (
        $rose(CPU_SUSPEND) && PUSH_STB && kind == K_MASK
        |-> $past(INSTR_END) || $past(mode) != MODE_RUN)
        else $error("maskable entry not at instruction end");

    chk_prio_load: assert property (
        VEC_STB && kind == K_MASK |-> cur_prio == $past(fld[sel_vec]))
        else $error("entry priority not from vector field");

    chk_vec_addr: assert property (
        VEC_STB && kind == K_MASK
        |-> VEC_ADDR == VEC_BASE - 16'({sel_vec, 1'b0}))
        else $error("wrong maskable vector address");

    chk_interrupt_return_instr_restore: assert property (
        $rose(POP_STB) |-> s_pop ##1 (!POP_STB && cur_prio
        == {$past(POP_DATA[CC_HI_BIT], 5), $past(POP_DATA[CC_LO_BIT], 5)}))
        else $error("return did not restore priority");

    chk_nmi_level: assert property (
        VEC_STB && kind != K_MASK |-> cur_prio == PRIO_L3)
        else $error("non-maskable entry not at level 3");

    chk_strict_above: assert property (
        VEC_STB && kind == K_MASK |-> npic_lvl($past(fld[sel_vec])) > cap_l)
        else $error("serviced request not above current level");

    chk_reset_first: assert property (
        VEC_STB && $past(reset_go) |-> VEC_ADDR == VEC_RESET && !depth[0])
        else $error("reset routine not entered first");

    chk_level0_kept: assert property (
        !any_l0)
        else $error("level 0 code stored in a vector field");

    chk_concurrent_hold: assert property (
        $rose(PUSH_STB) && kind == K_MASK |-> nested || depth == 4'h0)
        else $error("handler preempted in concurrent mode");

endmodule

/* File: tb/npic_cpu_model.sv */
// cpu core model: instruction ends and the stacked condition byte
`timescale 1ns/1ps
module npic_cpu_model
    import npic_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       PUSH_STB,
    input  wire logic [2:0] PUSH_SEL,
    input  wire logic       POP_STB,
    input  wire logic [2:0] POP_SEL,
    input  wire logic [1:0] CUR_PRIO,
    output logic            INSTR_END,
    output logic      [7:0] POP_DATA
);
    logic [7:0] stk [$];
    logic [7:0] top;
    // irregular boundaries, so entry must wait for them
    always @(posedge CLK) begin
        INSTR_END <= RESET ? 1'h0 : ($urandom_range(0, 2) == 0);
    end
    // condition byte kept on entry, handed back on return
    always @(posedge CLK) begin
        if (RESET) begin
            stk.delete();
            top <= 8'h00;
        end else if (PUSH_STB && PUSH_SEL == SEL_CC) begin
            stk.push_back({2'h3, CUR_PRIO[1], 1'h0, CUR_PRIO[0], 3'h0});
            top <= {2'h3, CUR_PRIO[1], 1'h0, CUR_PRIO[0], 3'h0};
        end else if (POP_STB && POP_SEL == SEL_CC && stk.size() > 0) begin
            void'(stk.pop_back());
            top <= (stk.size() > 0) ? stk[$] : 8'h00;
        end
    end
    // off the pop slot the byte is inverted so a stray sample shows
    assign POP_DATA = (POP_STB && POP_SEL == SEL_CC) ? top : ~top;
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
module tb_top
    import npic_pkg::*;
;
    logic        CLK = 1'h0, RESET = 1'h1, HSEL = 1'h0, HWRITE = 1'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [1:0]  HTRANS = 2'h0, PRIO_VAL = 2'h0, CUR_PRIO, SLEEP_MODE, cur_m;
    logic [2:0]  HSIZE = HSIZE_WORD, PUSH_SEL, POP_SEL;
    logic        HREADYOUT, HRESP, INSTR_END, CPU_SUSPEND, PUSH_STB;
    logic        POP_STB, VEC_STB, WAKE_STB, TRAP_REQ = 1'h0;
    logic        INTERRUPT_RETURN_INSTR_REQ = 1'h0, PRIO_LOAD = 1'h0, WAIT_ENTER = 1'h0;
    logic        HALT_ENTER = 1'h0;
    logic [7:0]  POP_DATA, prio_m [4];
    logic [15:0] EXT_PIN = 16'hFFFF, VEC_ADDR;
    logic [13:0] PERIPH_FLAG = 14'h0, PERIPH_EN = 14'h0, PERIPH_CLR = 14'h0;
    logic [1:0]  lvl_q [$];
    int          fails = 0, samples_checked = 0, pushes = 0, pops = 0;
    logic [7:0]  offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18,
                              8'h1C, 8'h20, 8'h40};
    logic [31:0] rstv [9] = '{32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hE8,
                              32'h0, 32'h1111, 32'h1, 32'h0};
    npic_ctrl u_npic_ctrl (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .INSTR_END(INSTR_END),
        .TRAP_REQ(TRAP_REQ), .INTERRUPT_RETURN_INSTR_REQ(INTERRUPT_RETURN_INSTR_REQ), .POP_DATA(POP_DATA),
        .PRIO_LOAD(PRIO_LOAD), .PRIO_VAL(PRIO_VAL), .WAIT_ENTER(WAIT_ENTER),
        .HALT_ENTER(HALT_ENTER), .EXT_PIN(EXT_PIN), .PERIPH_FLAG(PERIPH_FLAG),
        .PERIPH_EN(PERIPH_EN), .PERIPH_CLR(PERIPH_CLR),
        .CPU_SUSPEND(CPU_SUSPEND), .PUSH_STB(PUSH_STB), .PUSH_SEL(PUSH_SEL),
        .POP_STB(POP_STB), .POP_SEL(POP_SEL), .VEC_STB(VEC_STB),
        .VEC_ADDR(VEC_ADDR), .CUR_PRIO(CUR_PRIO), .SLEEP_MODE(SLEEP_MODE),
        .WAKE_STB(WAKE_STB));
    npic_cpu_model u_npic_cpu_model (.CLK(CLK), .RESET(RESET),
        .PUSH_STB(PUSH_STB), .PUSH_SEL(PUSH_SEL), .POP_STB(POP_STB),
        .POP_SEL(POP_SEL), .CUR_PRIO(CUR_PRIO), .INSTR_END(INSTR_END),
        .POP_DATA(POP_DATA));
    initial forever #5 CLK = ~CLK;
    task automatic chk(input string w, input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one single word transfer; the master waits on hready, never a count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        @(posedge CLK);
        while (HREADYOUT !== 1'h1) @(posedge CLK);
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADYOUT !== 1'h1) @(posedge CLK);
        rd = HRDATA;
    endtask
    function automatic logic [1:0] fld(input int v);
        return prio_m[v / 4][2 * (v % 4) +: 2];
    endfunction
    task automatic wprio(input int r, input logic [7:0] d);
        bus(1'h1, 8'(4 * r), {24'h0, d});
        for (int f = 0; f < 4; f++)
            if (d[2 * f +: 2] != PRIO_L0) prio_m[r][2 * f +: 2] = d[2 * f +: 2];
        if (r == 3) prio_m[3][7:4] = 4'hF;
        bus(1'h0, 8'(4 * r), 32'h0);
        chk("priority byte", rd, {24'h0, prio_m[r]});
    endtask
    task automatic pulse(input logic [2:0] k);
        @(posedge CLK);
        {TRAP_REQ, INTERRUPT_RETURN_INSTR_REQ, PRIO_LOAD} <= k;
        @(posedge CLK);
        {TRAP_REQ, INTERRUPT_RETURN_INSTR_REQ, PRIO_LOAD} <= 3'h0;
    endtask
    task automatic setlvl(input logic [1:0] c);
        PRIO_VAL <= c;
        pulse(3'h1);
        cur_m = c;
    endtask
    task automatic serve(input logic [15:0] a, input logic [1:0] p);
        int n;
        n = 0;
        @(negedge CLK);
        while (VEC_STB !== 1'h1 && n < 300) begin
            @(negedge CLK);
            n++;
        end
        chk("vector", {14'h0, CPU_SUSPEND, VEC_STB, VEC_ADDR},
            {16'h1, a});
        chk("level", {30'h0, CUR_PRIO}, {30'h0, p});
        chk("pushes", 32'(pushes), (a == VEC_RESET) ? 32'h0 : 32'h5);
        lvl_q.push_back(cur_m);
        cur_m = p;
        pushes = 0;
    endtask
    task automatic ret();
        int n;
        n = 0;
        pulse(3'h2);
        while (pops < 5 && n < 50) begin
            @(negedge CLK);
            n++;
        end
        @(negedge CLK);
        cur_m = lvl_q.pop_back();
        chk("restore", {30'(pops), CUR_PRIO}, {30'h5, cur_m});
        pops = 0;
    endtask
    // peripheral handler: clear sequence drops flag and latch
    task automatic handle(input int v);
        serve(VEC_BASE - 16'(2 * v), fld(v));
        @(posedge CLK);
        PERIPH_FLAG[v] <= 1'h0;
        PERIPH_CLR[v] <= 1'h1;
        @(posedge CLK);
        PERIPH_CLR <= 14'h0;
        ret();
    endtask
    task automatic quiet();
        int n;
        n = 0;
        repeat (40) begin
            @(negedge CLK);
            if (VEC_STB === 1'h1) n++;
        end
        chk("no service", 32'(n), 32'h0);
    endtask
    // stack strobes come in the documented order
    always @(negedge CLK) begin
        if (PUSH_STB === 1'h1) begin
            chk("push order", {29'h0, PUSH_SEL}, 32'(pushes));
            pushes++;
        end
        if (POP_STB === 1'h1) begin
            chk("pop order", {29'h0, POP_SEL}, 32'(4 - pops));
            pops++;
        end
    end
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(53548));
        foreach (prio_m[i]) prio_m[i] = 8'hFF;
        cur_m = PRIO_L3;
        repeat (5) @(posedge CLK);
        RESET <= 1'h0;
        serve(VEC_RESET, PRIO_L3);
        lvl_q.delete();
        for (int i = 0; i < 9; i++) begin
            bus(1'h0, offs[i], 32'h0);
            chk("reset value", rd, rstv[i]);
        end
        for (int i = 0; i < 12; i++) wprio(i % 4, 8'($urandom));
        wprio(2, 8'h51);
        $display("test registers done");
        pulse(3'h4);
        serve(VEC_TRAP, PRIO_L3);
        ret();
        setlvl(PRIO_L0);
        PERIPH_EN <= 14'h0F00;
        PERIPH_FLAG <= 14'h0300;
        handle(9);
        handle(8);
        PERIPH_FLAG <= 14'h0C00;
        handle(10);
        handle(11);
        $display("test maskable done");
        setlvl(PRIO_L3);
        PERIPH_FLAG[10] <= 1'h1;
        repeat (4) @(posedge CLK);
        PERIPH_FLAG[10] <= 1'h0;
        PERIPH_CLR[10] <= 1'h1;
        @(posedge CLK);
        PERIPH_CLR <= 14'h0;
        setlvl(PRIO_L0);
        quiet();
        bus(1'h1, OFF_SENSE, 32'h2);
        EXT_PIN <= 16'hFFFE;
        handle(2);
        quiet();
        $display("test clear and external done");
        print_verdict();
    end
endmodule
